// *** tlbt_pkg.sv ***
// Constants, field layout and state codes of the translation buffer test port
package tlbt_pkg;
	// ---------------------------------------------------------------
	// Buffer geometry
	// ---------------------------------------------------------------
	localparam int WAYS = 4;
	localparam int SETS = 8;
	localparam int IDX_W = 3;
	localparam int WAY_W = 2;
	localparam int LA_W = 20;
	localparam int TAG_W = 24;
	localparam int PPN_W = 20;
	localparam int LRU_W = 3;
	localparam int ENT_W = TAG_W + PPN_W;

	// ---------------------------------------------------------------
	// Entry layout: {linear page, valid, dirty, user, writable, page}
	// ---------------------------------------------------------------
	localparam int ENT_LA_LSB = PPN_W + 4;
	localparam int ENT_V = PPN_W + 3;
	localparam int ENT_D = PPN_W + 2;
	localparam int ENT_U = PPN_W + 1;
	localparam int ENT_R = PPN_W;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam int ADR_W = 4;
	localparam logic [ADR_W-1:0] OFF_DATA = 4'h0;
	localparam logic [ADR_W-1:0] OFF_CTRL = 4'h4;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] DATA_WMASK = 32'hFFFF_F01C;
	localparam logic [31:0] CTRL_WMASK = 32'hFFFF_FFE1;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int PA_LSB = 12;
	localparam int LRU_LSB = 7;
	localparam int HIT_BIT = 4;
	localparam int WAY_LSB = 2;
	localparam int V_BIT = 11;
	localparam int D_LSB = 9;
	localparam int U_LSB = 7;
	localparam int R_LSB = 5;
	localparam int CMD_BIT = 0;

	// ---------------------------------------------------------------
	// Attribute pair codes
	// ---------------------------------------------------------------
	localparam logic [1:0] PAIR_NONE = 2'h0;
	localparam logic [1:0] PAIR_CLR = 2'h1;
	localparam logic [1:0] PAIR_SET = 2'h2;
	localparam logic [1:0] PAIR_ANY = 2'h3;

	typedef enum logic [2:0] {
		TLBT_IDLE = 3'h1,
		TLBT_READ = 3'h2,
		TLBT_EXEC = 3'h4
	} tlbt_state_e;
endpackage

// *** tlbt_mem.sv ***
// One way of entry storage with registered read data
`timescale 1ns/1ps
module tlbt_mem #(
	parameter int W = 44,
	parameter int D = 8,
	parameter int AW = 3
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [W-1:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [W-1:0] o_rdata
);
	logic [W-1:0] mem [D];
	logic [D-1:0] vld_q;

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// Written flags so that untouched entries read as empty
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			vld_q <= '0;
		end else if (i_we) begin
			vld_q[i_waddr] <= 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else if (vld_q[i_raddr]) begin
			o_rdata <= mem[i_raddr];
		end else begin
			o_rdata <= '0;
		end
	end
endmodule

// *** tlbt_lru.sv ***
// Per-set replacement-order bits with registered read and victim choice
`timescale 1ns/1ps
module tlbt_lru (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [tlbt_pkg::IDX_W-1:0] i_raddr,
	input wire logic i_upd,
	input wire logic [tlbt_pkg::IDX_W-1:0] i_uidx,
	input wire logic [tlbt_pkg::WAY_W-1:0] i_uway,
	output logic [tlbt_pkg::LRU_W-1:0] o_lru,
	output logic [tlbt_pkg::WAY_W-1:0] o_victim
);
	logic [tlbt_pkg::LRU_W-1:0] lru_q [tlbt_pkg::SETS];

	// ---------------------------------------------------------------
	// Update on access: bit0 pair 0/1 recent, bit1 way 0, bit2 way 2
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			for (int s = 0; s < tlbt_pkg::SETS; s++) begin
				lru_q[s] <= '0;
			end
		end else if (i_upd) begin
			if (i_uway[1] == 1'b0) begin
				lru_q[i_uidx][0] <= 1'b1;
				lru_q[i_uidx][1] <= (i_uway[0] == 1'b0);
			end else begin
				lru_q[i_uidx][0] <= 1'b0;
				lru_q[i_uidx][2] <= (i_uway[0] == 1'b0);
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_lru <= '0;
		end else begin
			o_lru <= lru_q[i_raddr];
		end
	end

	// Victim is the least recent way of the opposite pair
	always_comb begin
		if (o_lru[0]) begin
			o_victim = o_lru[2] ? 2'h3 : 2'h2;
		end else begin
			o_victim = o_lru[1] ? 2'h1 : 2'h0;
		end
	end
endmodule

// *** tlbt_top.sv ***
// Translation buffer test port with its Wishbone register slave
//
// Behaviour
// - Thirty-two entries, four ways, tag plus page.
// - Tag is linear page, valid, three attributes.
// - Write stores data page into chosen entry.
// - Data bits 31:12 supply written page.
// - Lookup loads matching page into data 31:12.
// - Lookup returns prior order bits; write ignores.
// - Data bit 4 reports lookup hit.
// - Forced write uses way field bits 3:2.
// - Hit reports matching way in bits 3:2.
// - Lookup searches with control bits 31:12.
// - Lookup refreshes other fields from match.
// - Write allocates entry to control page.
// - Control bit 11 validates or invalidates entry.
// - Attribute pairs 01 clear, 10 set.
// - Attribute pairs steer lookup matching.
// - Control bit 0: lookup one, write zero.
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
module tlbt_top (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [tlbt_pkg::ADR_W-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack
);
	tlbt_pkg::tlbt_state_e state_q;
	logic [31:0] data_q;
	logic [31:0] ctrl_q;
	logic wb_req;
	logic wr_data;
	logic wr_ctrl;
	logic [31:0] bmask;
	logic [tlbt_pkg::IDX_W-1:0] set_idx;
	logic [tlbt_pkg::ENT_W-1:0] ent_rd [tlbt_pkg::WAYS];
	logic [tlbt_pkg::WAYS-1:0] way_hit;
	logic hit;
	logic [tlbt_pkg::WAY_W-1:0] hit_way;
	logic [tlbt_pkg::ENT_W-1:0] hit_ent;
	logic [tlbt_pkg::LRU_W-1:0] lru_rd;
	logic [tlbt_pkg::WAY_W-1:0] victim;
	logic is_exec;
	logic do_look;
	logic do_write;
	logic forced;
	logic [tlbt_pkg::WAY_W-1:0] wr_way;
	logic [tlbt_pkg::ENT_W-1:0] wr_ent;
	logic lru_upd;
	logic [tlbt_pkg::WAY_W-1:0] lru_way;

	function automatic logic attr_match(input logic [1:0] pair, input logic bit_v);
		case (pair)
			tlbt_pkg::PAIR_NONE: attr_match = 1'b0;
			tlbt_pkg::PAIR_CLR: attr_match = ~bit_v;
			tlbt_pkg::PAIR_SET: attr_match = bit_v;
			default: attr_match = 1'b1;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack & (state_q == tlbt_pkg::TLBT_IDLE);
	assign wr_data = wb_req & i_wb_we & (i_wb_adr == tlbt_pkg::OFF_DATA);
	assign wr_ctrl = wb_req & i_wb_we & (i_wb_adr == tlbt_pkg::OFF_CTRL);
	assign bmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= wb_req;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_wb_dat <= tlbt_pkg::RD_ZERO;
		end else if (wb_req & ~i_wb_we) begin
			if (i_wb_adr == tlbt_pkg::OFF_DATA) begin
				o_wb_dat <= data_q;
			end else if (i_wb_adr == tlbt_pkg::OFF_CTRL) begin
				o_wb_dat <= ctrl_q;
			end else begin
				o_wb_dat <= tlbt_pkg::RD_ZERO;
			end
		end
	end

	// ---------------------------------------------------------------
	// Operation sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_q <= tlbt_pkg::TLBT_IDLE;
		end else begin
			case (state_q)
				tlbt_pkg::TLBT_IDLE: begin
					if (wr_ctrl) begin
						state_q <= tlbt_pkg::TLBT_READ;
					end
				end
				tlbt_pkg::TLBT_READ: state_q <= tlbt_pkg::TLBT_EXEC;
				tlbt_pkg::TLBT_EXEC: state_q <= tlbt_pkg::TLBT_IDLE;
				default: state_q <= tlbt_pkg::TLBT_IDLE;
			endcase
		end
	end

	assign is_exec = (state_q == tlbt_pkg::TLBT_EXEC);
	assign do_look = is_exec & ctrl_q[tlbt_pkg::CMD_BIT];
	assign do_write = is_exec & ~ctrl_q[tlbt_pkg::CMD_BIT];
	assign set_idx = ctrl_q[tlbt_pkg::PA_LSB +: tlbt_pkg::IDX_W];

	// ---------------------------------------------------------------
	// Entry storage, one memory per way
	// ---------------------------------------------------------------
	// Entry: {linear page, valid, dirty, user, writable, page}
	assign wr_ent = {ctrl_q[31:tlbt_pkg::PA_LSB], ctrl_q[tlbt_pkg::V_BIT],
		ctrl_q[tlbt_pkg::D_LSB+1], ctrl_q[tlbt_pkg::U_LSB+1], ctrl_q[tlbt_pkg::R_LSB+1],
		data_q[31:tlbt_pkg::PA_LSB]};
	assign forced = data_q[tlbt_pkg::HIT_BIT];
	assign wr_way = forced ? data_q[tlbt_pkg::WAY_LSB +: tlbt_pkg::WAY_W] : victim;

	for (genvar g = 0; g < tlbt_pkg::WAYS; g++) begin : g_way
		localparam int WAY_ID = g;
		tlbt_mem #(
			.W(tlbt_pkg::ENT_W),
			.D(tlbt_pkg::SETS),
			.AW(tlbt_pkg::IDX_W)
		) u_mem (
			.i_core_clk(i_core_clk),
			.i_rst(i_rst),
			.i_we(do_write & (wr_way == WAY_ID[tlbt_pkg::WAY_W-1:0])),
			.i_waddr(set_idx),
			.i_wdata(wr_ent),
			.i_raddr(set_idx),
			.o_rdata(ent_rd[g])
		);
		// Match on page, valid and each attribute pair
		assign way_hit[g] = ent_rd[g][tlbt_pkg::ENT_V]
			& (ent_rd[g][tlbt_pkg::ENT_LA_LSB +: tlbt_pkg::LA_W] == ctrl_q[31:tlbt_pkg::PA_LSB])
			& attr_match(ctrl_q[tlbt_pkg::D_LSB +: 2], ent_rd[g][tlbt_pkg::ENT_D])
			& attr_match(ctrl_q[tlbt_pkg::U_LSB +: 2], ent_rd[g][tlbt_pkg::ENT_U])
			& attr_match(ctrl_q[tlbt_pkg::R_LSB +: 2], ent_rd[g][tlbt_pkg::ENT_R]);
	end

	// Lowest matching way wins
	always_comb begin
		hit_way = '0;
		for (int w = tlbt_pkg::WAYS - 1; w >= 0; w--) begin
			if (way_hit[w]) begin
				hit_way = w[tlbt_pkg::WAY_W-1:0];
			end
		end
	end
	assign hit = |way_hit;
	assign hit_ent = ent_rd[hit_way];

	// ---------------------------------------------------------------
	// Replacement order
	// ---------------------------------------------------------------
	assign lru_upd = do_write | (do_look & hit);
	assign lru_way = do_write ? wr_way : hit_way;

	tlbt_lru u_lru (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_raddr(set_idx),
		.i_upd(lru_upd),
		.i_uidx(set_idx),
		.i_uway(lru_way),
		.o_lru(lru_rd),
		.o_victim(victim)
	);

	// ---------------------------------------------------------------
	// Test registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			data_q <= tlbt_pkg::DATA_RST;
		end else if (wr_data) begin
			data_q <= (data_q & ~(bmask & tlbt_pkg::DATA_WMASK))
				| (i_wb_dat & bmask & tlbt_pkg::DATA_WMASK);
		end else if (do_look) begin
			data_q[tlbt_pkg::LRU_LSB +: tlbt_pkg::LRU_W] <= lru_rd;
			data_q[tlbt_pkg::HIT_BIT] <= hit;
			if (hit) begin
				data_q[31:tlbt_pkg::PA_LSB] <= hit_ent[tlbt_pkg::PPN_W-1:0];
				data_q[tlbt_pkg::WAY_LSB +: tlbt_pkg::WAY_W] <= hit_way;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ctrl_q <= tlbt_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= (ctrl_q & ~(bmask & tlbt_pkg::CTRL_WMASK))
				| (i_wb_dat & bmask & tlbt_pkg::CTRL_WMASK);
		end else if (do_look & hit) begin
			ctrl_q[tlbt_pkg::V_BIT] <= 1'b1;
			ctrl_q[tlbt_pkg::D_LSB +: 2] <= hit_ent[tlbt_pkg::ENT_D] ? tlbt_pkg::PAIR_SET
				: tlbt_pkg::PAIR_CLR;
			ctrl_q[tlbt_pkg::U_LSB +: 2] <= hit_ent[tlbt_pkg::ENT_U] ? tlbt_pkg::PAIR_SET
				: tlbt_pkg::PAIR_CLR;
			ctrl_q[tlbt_pkg::R_LSB +: 2] <= hit_ent[tlbt_pkg::ENT_R] ? tlbt_pkg::PAIR_SET
				: tlbt_pkg::PAIR_CLR;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_op_seq;
		@(posedge i_core_clk) disable iff (i_rst)
		wr_ctrl |=> (state_q == tlbt_pkg::TLBT_READ) ##1 is_exec ##1
			(state_q == tlbt_pkg::TLBT_IDLE);
	endproperty
	a_op_seq: assert property (p_op_seq) else $error("operation sequence broken");

	property p_hit_flag;
		@(posedge i_core_clk) disable iff (i_rst)
		do_look |=> (data_q[tlbt_pkg::HIT_BIT] == $past(hit));
	endproperty
	a_hit_flag: assert property (p_hit_flag) else $error("hit flag wrong");

	property p_hit_page;
		@(posedge i_core_clk) disable iff (i_rst)
		(do_look && hit) |=>
			(data_q[31:tlbt_pkg::PA_LSB] == $past(hit_ent[tlbt_pkg::PPN_W-1:0]));
	endproperty
	a_hit_page: assert property (p_hit_page) else $error("lookup page wrong");

	property p_lru_before;
		@(posedge i_core_clk) disable iff (i_rst)
		do_look |=> (data_q[tlbt_pkg::LRU_LSB +: tlbt_pkg::LRU_W] == $past(lru_rd));
	endproperty
	a_lru_before: assert property (p_lru_before) else $error("order bits wrong");

	property p_hit_way;
		@(posedge i_core_clk) disable iff (i_rst)
		(do_look && hit) |=> (data_q[tlbt_pkg::WAY_LSB +: tlbt_pkg::WAY_W] == $past(hit_way))
			&& way_hit[data_q[tlbt_pkg::WAY_LSB +: tlbt_pkg::WAY_W]] == $past(hit);
	endproperty
	a_hit_way: assert property (p_hit_way) else $error("hit way wrong");

	property p_forced_way;
		@(posedge i_core_clk) disable iff (i_rst)
		(do_write && forced) |=> ##1
			(ent_rd[$past(data_q[tlbt_pkg::WAY_LSB +: tlbt_pkg::WAY_W], 2)] == $past(wr_ent, 2));
	endproperty
	a_forced_way: assert property (p_forced_way) else $error("forced way ignored");

	property p_victim_way;
		@(posedge i_core_clk) disable iff (i_rst)
		(do_write && !forced) |=> ##1
			(ent_rd[$past(victim, 2)] == $past(wr_ent, 2));
	endproperty
	a_victim_way: assert property (p_victim_way) else $error("victim way not used");

	property p_miss_keep;
		@(posedge i_core_clk) disable iff (i_rst)
		(do_look && !hit) |=> (ctrl_q == $past(ctrl_q))
			&& (data_q[31:tlbt_pkg::PA_LSB] == $past(data_q[31:tlbt_pkg::PA_LSB]));
	endproperty
	a_miss_keep: assert property (p_miss_keep) else $error("miss changed fields");

	property p_write_data;
		@(posedge i_core_clk) disable iff (i_rst)
		do_write |=> $stable(data_q);
	endproperty
	a_write_data: assert property (p_write_data) else $error("write changed data");

	property p_write_back;
		@(posedge i_core_clk) disable iff (i_rst)
		do_write ##1 (state_q == tlbt_pkg::TLBT_IDLE) ##0 wr_ctrl && i_wb_dat[0]
			&& (i_wb_adr == tlbt_pkg::OFF_CTRL) && (&i_wb_sel)
			&& (i_wb_dat[31:tlbt_pkg::PA_LSB] == $past(ctrl_q[31:tlbt_pkg::PA_LSB]))
			&& (i_wb_dat[tlbt_pkg::D_LSB +: 6] == 6'h3F) && $past(ctrl_q[tlbt_pkg::V_BIT])
			|=> ##1 hit;
	endproperty
	a_write_back: assert property (p_write_back) else $error("written entry not found");

	property p_pair_none;
		@(posedge i_core_clk) disable iff (i_rst)
		(is_exec && ctrl_q[tlbt_pkg::D_LSB +: 2] == tlbt_pkg::PAIR_NONE) |-> !hit;
	endproperty
	a_pair_none: assert property (p_pair_none) else $error("pair 00 matched");

	property p_ack_latency;
		@(posedge i_core_clk) disable iff (i_rst)
		(i_wb_cyc && i_wb_stb && !o_wb_ack) |-> ##[1:4] o_wb_ack;
	endproperty
	a_ack_latency: assert property (p_ack_latency) else $error("request not answered");

	property p_ack_once;
		@(posedge i_core_clk) disable iff (i_rst)
		o_wb_ack |=> !o_wb_ack;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");
endmodule

// *** tlb_test_access_tb.sv ***
// Self-checking testbench of the translation buffer test port
`timescale 1ns/1ps
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %0t %s", $time, m); end end
module tlb_test_access_tb;
	logic i_core_clk;
	logic i_rst;
	logic i_wb_cyc;
	logic i_wb_stb;
	logic i_wb_we;
	logic [tlbt_pkg::ADR_W-1:0] i_wb_adr;
	logic [3:0] i_wb_sel;
	logic [31:0] i_wb_dat;
	logic [31:0] o_wb_dat;
	logic o_wb_ack;
	logic [31:0] rd;
	int n_mismatch;
	int checks;

	tlbt_top uut (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_wb_cyc(i_wb_cyc),
		.i_wb_stb(i_wb_stb),
		.i_wb_we(i_wb_we),
		.i_wb_adr(i_wb_adr),
		.i_wb_sel(i_wb_sel),
		.i_wb_dat(i_wb_dat),
		.o_wb_dat(o_wb_dat),
		.o_wb_ack(o_wb_ack)
	);

	// ---------------------------------------------------------------
	// Clock and bus helpers
	// ---------------------------------------------------------------
	initial i_core_clk = 1'b0;
	always #50 i_core_clk = ~i_core_clk;

	task automatic wb(input logic we, input logic [tlbt_pkg::ADR_W-1:0] adr, input logic [31:0] wd,
		input logic [3:0] sel = 4'hF);
		int n;
		n = 0;
		@(posedge i_core_clk);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_adr <= adr;
		i_wb_dat <= wd;
		i_wb_sel <= sel;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 20);
		`CHK(o_wb_ack, 1'b1, "no ack")
		rd = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		i_wb_we <= 1'b0;
	endtask

	function automatic logic [31:0] ctl(logic [19:0] pg, logic v, logic [1:0] d, u, r, logic c);
		return {pg, v, d, u, r, 4'h0, c};
	endfunction

	function automatic logic [31:0] dat(logic [19:0] pa, logic [2:0] lru, logic pl, logic [1:0] way);
		return {pa, 2'h0, lru, 2'h0, pl, way, 2'h0};
	endfunction

	task automatic wrt(input logic [31:0] dv, input logic [31:0] cv);
		wb(1'b1, tlbt_pkg::OFF_DATA, dv);
		wb(1'b1, tlbt_pkg::OFF_CTRL, cv);
	endtask

	task automatic look(input logic [31:0] cv);
		wb(1'b1, tlbt_pkg::OFF_CTRL, cv);
		wb(1'b0, tlbt_pkg::OFF_DATA, 32'h0000_0000);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		wb(1'b0, tlbt_pkg::OFF_DATA, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000, "data reset")
		wb(1'b0, tlbt_pkg::OFF_CTRL, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000, "control reset")
	endtask

	task automatic t_masks;
		wb(1'b1, tlbt_pkg::OFF_DATA, 32'hFFFF_F39C);
		wb(1'b1, 4'h8, 32'h1234_5678);
		wb(1'b0, 4'h8, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000, "unmapped read")
		wb(1'b0, tlbt_pkg::OFF_DATA, 32'h0000_0000);
		`CHK(rd, 32'hFFFF_F01C, "data mask")
		wb(1'b1, tlbt_pkg::OFF_DATA, 32'h0000_0000, 4'h2);
		wb(1'b0, tlbt_pkg::OFF_DATA, 32'h0000_0000);
		`CHK(rd, 32'hFFFF_001C, "byte enable")
		wb(1'b1, tlbt_pkg::OFF_CTRL, 32'hFFFF_FFE1);
		wb(1'b0, tlbt_pkg::OFF_CTRL, 32'h0000_0000);
		`CHK(rd, 32'hFFFF_FFE1, "control after miss")
		wb(1'b0, tlbt_pkg::OFF_DATA, 32'h0000_0000);
		`CHK(rd, 32'hFFFF_000C, "data after empty miss")
	endtask

	task automatic t_forced;
		wrt(dat(20'hABCDE, 3'h7, 1'b1, 2'h2), ctl(20'h12342, 1'b1, 2'h2, 2'h1, 2'h2, 1'b0));
		look(ctl(20'h12342, 1'b1, 2'h3, 2'h3, 2'h3, 1'b1));
		`CHK(rd, dat(20'hABCDE, 3'h4, 1'b1, 2'h2), "forced hit")
		wb(1'b0, tlbt_pkg::OFF_CTRL, 32'h0000_0000);
		`CHK(rd, ctl(20'h12342, 1'b1, 2'h2, 2'h1, 2'h2, 1'b1), "control refresh")
		look(ctl(20'h55552, 1'b1, 2'h3, 2'h3, 2'h3, 1'b1));
		`CHK(rd, dat(20'hABCDE, 3'h4, 1'b0, 2'h2), "tag miss")
	endtask

	task automatic t_attr;
		logic [1:0] p [3];
		logic [2:0] eb;
		logic [1:0] c;
		eb = 3'b101;
		for (int f = 0; f < 3; f++) begin
			for (int k = 0; k < 4; k++) begin
				c = k[1:0];
				p[0] = 2'h3;
				p[1] = 2'h3;
				p[2] = 2'h3;
				p[f] = c;
				look(ctl(20'h12342, 1'b1, p[0], p[1], p[2], 1'b1));
				`CHK(rd[4], c[eb[f]], "attribute match")
			end
		end
	endtask

	task automatic t_inval;
		wrt(dat(20'h00000, 3'h0, 1'b1, 2'h2), ctl(20'h12342, 1'b0, 2'h2, 2'h1, 2'h2, 1'b0));
		look(ctl(20'h12342, 1'b1, 2'h3, 2'h3, 2'h3, 1'b1));
		`CHK(rd[4], 1'b0, "invalidated entry")
	endtask

	task automatic t_unforced;
		wrt(dat(20'h11111, 3'h7, 1'b0, 2'h3), ctl(20'h00015, 1'b1, 2'h1, 2'h1, 2'h1, 1'b0));
		look(ctl(20'h00015, 1'b1, 2'h3, 2'h3, 2'h3, 1'b1));
		`CHK(rd, dat(20'h11111, 3'h3, 1'b1, 2'h0), "victim way 0")
		wrt(dat(20'h22222, 3'h0, 1'b0, 2'h1), ctl(20'h00025, 1'b1, 2'h1, 2'h1, 2'h1, 1'b0));
		look(ctl(20'h00025, 1'b1, 2'h3, 2'h3, 2'h3, 1'b1));
		`CHK(rd, dat(20'h22222, 3'h6, 1'b1, 2'h2), "victim way 2")
		look(ctl(20'h00015, 1'b1, 2'h1, 2'h1, 2'h1, 1'b1));
		`CHK(rd, dat(20'h11111, 3'h6, 1'b1, 2'h0), "first entry kept")
	endtask

	// ---------------------------------------------------------------
	// Verdict, watchdog and main sequence
	// ---------------------------------------------------------------
	task automatic tally_and_finish;
		$display("Mismatches %0d, checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge i_core_clk);
		n_mismatch++;
		tally_and_finish;
	end

	initial begin
		n_mismatch = 0;
		checks = 0;
		i_rst = 1'b1;
		i_wb_cyc = 1'b0;
		i_wb_stb = 1'b0;
		i_wb_we = 1'b0;
		i_wb_adr = 4'h0;
		i_wb_sel = 4'hF;
		i_wb_dat = 32'h0000_0000;
		repeat (8) @(posedge i_core_clk);
		i_rst <= 1'b0;
		@(posedge i_core_clk);
		t_reset;
		t_masks;
		t_forced;
		t_attr;
		t_inval;
		t_unforced;
		tally_and_finish;
	end
endmodule
